// *** hdl/conv_out_pkg.sv ***
// constants for the converter output latency and power-mode block
package conv_out_pkg;
  localparam int          SAMPLE_W        = 12;
  localparam int          LAT_PLAIN       = 38;
  localparam int          LAT_CORR        = 50;
  localparam int          LAT_DECIM       = 74;
  localparam int          LAT_OVR         = 12;
  localparam int          RECOVER_OCLK    = 2;
  localparam int          PIPE_MAX        = 80;
  localparam int          CLK_MHZ         = 250;
  // wake-up times, ns
  localparam longint      WAKE_SHUT_NS    = 2500000;
  localparam longint      WAKE_STBY_NS    = 100000;
  localparam longint      WAKE_DEEP_NS    = 20000;
  localparam longint      WAKE_LIGHT_NS   = 2000;
  localparam int          WAKE_SHUT_CYC   = int'(WAKE_SHUT_NS * CLK_MHZ / 1000);
  localparam int          WAKE_STBY_CYC   = int'(WAKE_STBY_NS * CLK_MHZ / 1000);
  localparam int          WAKE_DEEP_CYC   = int'(WAKE_DEEP_NS * CLK_MHZ / 1000);
  localparam int          WAKE_LIGHT_CYC  = int'(WAKE_LIGHT_NS * CLK_MHZ / 1000);
  // register byte offsets
  localparam logic [7:0]  CTRL_OFS        = 8'h00;
  localparam logic [7:0]  POWER_MODE_OFS  = 8'h04;
  localparam logic [7:0]  STATUS_OFS      = 8'h08;
  // control fields
  localparam int          CTRL_CORR_BIT   = 0;
  localparam int          CTRL_DECIM_BIT  = 1;
  localparam int          CTRL_THR_LSB    = 4;
  localparam logic [3:0]  THR_RESET       = 4'hf;
  localparam logic [1:0]  PMODE_RESET     = 2'h0;
  typedef enum logic [1:0] {PM_SHUTDOWN, PM_STANDBY, PM_DEEP, PM_LIGHT} pmode_e;
endpackage : conv_out_pkg

// *** hdl/conv_out.sv ***
// two-channel converter output path: latency pipe, over-range, DDR link, sleep control
`timescale 1ns/1ps
module conv_out #(
  parameter int WAKE_SHUT_CYC  = conv_out_pkg::WAKE_SHUT_CYC,
  parameter int WAKE_STBY_CYC  = conv_out_pkg::WAKE_STBY_CYC,
  parameter int WAKE_DEEP_CYC  = conv_out_pkg::WAKE_DEEP_CYC,
  parameter int WAKE_LIGHT_CYC = conv_out_pkg::WAKE_LIGHT_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        link_clk,
  input  wire logic        link_rst,
  input  wire logic [11:0] chan_a_sample,
  input  wire logic [11:0] chan_b_sample,
  input  wire logic        enable_pin,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic      [5:0]  chan_a_data_pairs,
  output logic      [5:0]  chan_b_data_pairs,
  output logic             chan_a_forwarded_clock,
  output logic             chan_b_forwarded_clock,
  output logic             chan_a_overrange_flag,
  output logic             chan_b_overrange_flag,
  output logic             out_valid
);
  localparam int W = conv_out_pkg::SAMPLE_W;

  logic             corr_en_r;
  logic             decim_en_r;
  logic [3:0]       thr_r;
  logic [1:0]       pmode_r;
  logic             en_s1_r, en_s2_r;
  logic             awake_r;
  logic [31:0]      wake_cnt_r;
  logic [6:0]       fill_cnt_r;
  logic [6:0]       lat_sel;
  logic [W-1:0]     pipe_a_r [conv_out_pkg::PIPE_MAX];
  logic [W-1:0]     pipe_b_r [conv_out_pkg::PIPE_MAX];
  logic [1:0]       ovr_pipe_r [conv_out_pkg::LAT_OVR];
  logic [W-1:0]     out_a_r, out_b_r;
  logic             out_ovr_a_r, out_ovr_b_r;
  logic             ovr_a, ovr_b;
  logic [15:0]      thr_level;
  logic             decim_ph_r;
  logic             cfg_chg;
  logic             wb_hit;

  // enable pin comes from outside, two flops before use
  always_ff @(posedge core_clk) begin
    if (rst) begin
      en_s1_r <= 1'b0;
      en_s2_r <= 1'b0;
    end else begin
      en_s1_r <= enable_pin;
      en_s2_r <= en_s1_r;
    end
  end

  // wishbone slave: one wait cycle, ack drops after one cycle
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0;
      corr_en_r  <= 1'b0;
      decim_en_r <= 1'b0;
      thr_r      <= conv_out_pkg::THR_RESET;
      pmode_r    <= conv_out_pkg::PMODE_RESET;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= 32'h0;
      if (wb_hit && wb_we_i && wb_sel_i[0]) begin
        unique case (wb_adr_i)
          conv_out_pkg::CTRL_OFS: begin
            corr_en_r  <= wb_dat_i[conv_out_pkg::CTRL_CORR_BIT];
            decim_en_r <= wb_dat_i[conv_out_pkg::CTRL_DECIM_BIT];
            thr_r      <= wb_dat_i[conv_out_pkg::CTRL_THR_LSB +: 4];
          end
          conv_out_pkg::POWER_MODE_OFS: pmode_r <= wb_dat_i[1:0];
          default: ;
        endcase
      end
      if (wb_hit && !wb_we_i) begin
        unique case (wb_adr_i)
          conv_out_pkg::CTRL_OFS:
            wb_dat_o <= {24'h0, thr_r, 2'b00, decim_en_r, corr_en_r};
          conv_out_pkg::POWER_MODE_OFS: wb_dat_o <= {30'h0, pmode_r};
          conv_out_pkg::STATUS_OFS: wb_dat_o <= {29'h0, out_valid, awake_r, en_s2_r};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // sleep while enable low; wake counter sized by chosen mode
  always_ff @(posedge core_clk) begin
    if (rst) begin
      awake_r    <= 1'b0;
      wake_cnt_r <= 32'h0;
    end else if (!en_s2_r) begin
      awake_r <= 1'b0;
      unique case (conv_out_pkg::pmode_e'(pmode_r))
        conv_out_pkg::PM_SHUTDOWN: wake_cnt_r <= 32'(WAKE_SHUT_CYC);
        conv_out_pkg::PM_STANDBY:  wake_cnt_r <= 32'(WAKE_STBY_CYC);
        conv_out_pkg::PM_DEEP:     wake_cnt_r <= 32'(WAKE_DEEP_CYC);
        conv_out_pkg::PM_LIGHT:    wake_cnt_r <= 32'(WAKE_LIGHT_CYC);
      endcase
    end else if (wake_cnt_r != 32'h0) begin
      wake_cnt_r <= wake_cnt_r - 32'h1;
    end else begin
      awake_r <= 1'b1;
    end
  end

  // latency choice; correction takes priority over decimation
  always_comb begin
    if (corr_en_r)
      lat_sel = 7'(conv_out_pkg::LAT_CORR);
    else if (decim_en_r)
      lat_sel = 7'(conv_out_pkg::LAT_DECIM);
    else
      lat_sel = 7'(conv_out_pkg::LAT_PLAIN);
  end

  // sample shift pipes; taps chosen by latency, one stage is the output flop
  always_ff @(posedge core_clk) begin
    pipe_a_r[0] <= chan_a_sample;
    pipe_b_r[0] <= chan_b_sample;
    for (int i = 1; i < conv_out_pkg::PIPE_MAX; i++) begin
      pipe_a_r[i] <= pipe_a_r[i-1];
      pipe_b_r[i] <= pipe_b_r[i-1];
    end
  end

  // decimation keeps every second sample and holds it for two clocks
  always_ff @(posedge core_clk) begin
    if (rst) begin
      out_a_r    <= '0;
      out_b_r    <= '0;
      decim_ph_r <= 1'b0;
    end else begin
      decim_ph_r <= ~decim_ph_r;
      if (!decim_en_r || corr_en_r || decim_ph_r) begin
        out_a_r <= pipe_a_r[lat_sel - 7'd2];
        out_b_r <= pipe_b_r[lat_sel - 7'd2];
      end
    end
  end

  // fast over-range compare against thr/16 of full scale (magnitude from mid-code)
  assign thr_level = 16'({thr_r, 11'h0} >> 4);
  function automatic logic over(input logic [W-1:0] s, input logic [15:0] lvl);
    logic [W-1:0] mag;
    mag = s[W-1] ? (s - 12'h800) : (12'h7ff - s);
    return {4'h0, mag} >= lvl;
  endfunction
  assign ovr_a = over(chan_a_sample, thr_level);
  assign ovr_b = over(chan_b_sample, thr_level);

  // short over-range pipe, independent of data latency
  always_ff @(posedge core_clk) begin
    ovr_pipe_r[0] <= {ovr_b, ovr_a};
    for (int i = 1; i < conv_out_pkg::LAT_OVR; i++)
      ovr_pipe_r[i] <= ovr_pipe_r[i-1];
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      out_ovr_a_r <= 1'b0;
      out_ovr_b_r <= 1'b0;
    end else begin
      out_ovr_a_r <= ovr_pipe_r[conv_out_pkg::LAT_OVR-2][0];
      out_ovr_b_r <= ovr_pipe_r[conv_out_pkg::LAT_OVR-2][1];
    end
  end

  // refill count after a settings change or wake-up
  logic corr_q_r, decim_q_r;
  assign cfg_chg = (corr_q_r != corr_en_r) || (decim_q_r != decim_en_r);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      corr_q_r   <= 1'b0;
      decim_q_r  <= 1'b0;
      fill_cnt_r <= 7'(conv_out_pkg::PIPE_MAX);
    end else begin
      corr_q_r  <= corr_en_r;
      decim_q_r <= decim_en_r;
      if (cfg_chg || !awake_r)
        fill_cnt_r <= 7'(conv_out_pkg::PIPE_MAX);
      else if (fill_cnt_r != 7'h0)
        fill_cnt_r <= fill_cnt_r - 7'h1;
    end
  end
  // a settings change drops valid in its own cycle, before the refill count reloads
  assign out_valid = awake_r && !cfg_chg && (fill_cnt_r == 7'h0);

  // link domain: samples held many link clocks; words settle before capture
  // limitation: link domain samples a free-running word, no per-word handshake
  logic [25:0] lk_s1_r, lk_s2_r, lk_word_r;
  logic        lk_ph_r;
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      lk_s1_r   <= '0;
      lk_s2_r   <= '0;
      lk_word_r <= '0;
      lk_ph_r   <= 1'b0;
    end else begin
      lk_s1_r <= {out_ovr_b_r, out_ovr_a_r, out_b_r, out_a_r};
      lk_s2_r <= lk_s1_r;
      lk_ph_r <= ~lk_ph_r;
      if (lk_ph_r)
        lk_word_r <= lk_s2_r;
    end
  end

  // ddr: low half while forwarded clock high, high half while low
  assign chan_a_forwarded_clock = lk_ph_r;
  assign chan_b_forwarded_clock = lk_ph_r;
  assign chan_a_data_pairs      = lk_ph_r ? lk_word_r[5:0]   : lk_word_r[11:6];
  assign chan_b_data_pairs      = lk_ph_r ? lk_word_r[17:12] : lk_word_r[23:18];
  assign chan_a_overrange_flag  = lk_word_r[24];
  assign chan_b_overrange_flag  = lk_word_r[25];

  // is analog settling; digital path adds no recovery beyond the pipe

  // named pieces for the checks
  sequence s_plain_mode;
    !corr_en_r && !decim_en_r;
  endsequence

  chk_plain_latency: assert property (@(posedge core_clk) disable iff (rst)
    s_plain_mode ##0 (!corr_en_r && !decim_en_r)[*1] ##1 (!corr_en_r && !decim_en_r && out_valid)
      |-> out_a_r == $past(chan_a_sample, conv_out_pkg::LAT_PLAIN))
    else $error("plain latency wrong");
  chk_corr_latency: assert property (@(posedge core_clk) disable iff (rst)
    corr_en_r && $past(corr_en_r) && out_valid |-> out_b_r == $past(chan_b_sample, conv_out_pkg::LAT_CORR))
    else $error("corrected latency wrong");
  chk_decim_latency: assert property (@(posedge core_clk) disable iff (rst)
    decim_en_r && !corr_en_r && $past(decim_en_r) && !$past(corr_en_r) && !decim_ph_r && out_valid
      |-> out_a_r == $past(chan_a_sample, conv_out_pkg::LAT_DECIM))
    else $error("decimated latency wrong");
  chk_ovr_latency: assert property (@(posedge core_clk) disable iff (rst)
    $past(ovr_a, conv_out_pkg::LAT_OVR) |-> out_ovr_a_r)
    else $error("over-range latency wrong");
  chk_thr_reset: assert property (@(posedge core_clk)
    $past(rst) |-> thr_r == conv_out_pkg::THR_RESET)
    else $error("threshold reset value wrong");
  chk_sleep_entry: assert property (@(posedge core_clk) disable iff (rst)
    !en_s2_r |=> !awake_r && !out_valid)
    else $error("not asleep while enable low");
  chk_light_wake: assert property (@(posedge core_clk) disable iff (rst)
    $rose(en_s2_r) && pmode_r == 2'h3 |-> !awake_r [*2])
    else $error("woke too early");
  chk_cfg_invalid: assert property (@(posedge core_clk) disable iff (rst)
    cfg_chg |=> !out_valid [*8])
    else $error("valid during refill");
  chk_wb_ack: assert property (@(posedge core_clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
endmodule : conv_out

// *** verif/ddr_capture.sv ***
// receiver model: rebuilds 12-bit words and the flag from one ddr link channel
`timescale 1ns/1ps
module ddr_capture (
  input  wire logic        link_clk,
  input  wire logic        fwd_clk,
  input  wire logic [5:0]  pairs,
  input  wire logic        ovr,
  input  wire logic        valid,
  output logic      [11:0] word,
  output logic             flag
);
  logic [5:0] hi_r;
  // sample mid-cycle; a new word shows its high half first, then its low half
  always @(negedge link_clk) begin
    if (!fwd_clk) begin
      hi_r <= pairs;
    end else if (valid) begin
      word <= {hi_r, pairs};
    end
    flag <= ovr;
  end
endmodule : ddr_capture

// *** verif/tb_conv_out.sv ***
// testbench for the converter output block: registers, sleep modes, latencies, over-range
`timescale 1ns/1ps
module tb_conv_out;
  localparam int WAKE_SIM[4] = '{20, 10, 6, 3};
  localparam int LAT[4]      = '{conv_out_pkg::LAT_PLAIN, conv_out_pkg::LAT_CORR,
                                 conv_out_pkg::LAT_DECIM, conv_out_pkg::LAT_CORR};
  logic        core_clk, rst, link_clk, link_rst, enable_pin;
  logic        cyc, stb, we, ack, valid, fck_a, fck_b, ovr_a, ovr_b, flag_a, flag_b;
  logic [11:0] samp_a, samp_b, word_a, word_b, mk;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, dat_o, rdat;
  logic [5:0]  pr_a, pr_b;
  int          err_total, total_checks, cyc_cnt, n;

  conv_out #(.WAKE_SHUT_CYC(20), .WAKE_STBY_CYC(10), .WAKE_DEEP_CYC(6), .WAKE_LIGHT_CYC(3)) dut (
    .core_clk(core_clk), .rst(rst), .link_clk(link_clk), .link_rst(link_rst),
    .chan_a_sample(samp_a), .chan_b_sample(samp_b), .enable_pin(enable_pin),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .chan_a_data_pairs(pr_a), .chan_b_data_pairs(pr_b),
    .chan_a_forwarded_clock(fck_a), .chan_b_forwarded_clock(fck_b),
    .chan_a_overrange_flag(ovr_a), .chan_b_overrange_flag(ovr_b), .out_valid(valid));
  ddr_capture rx_a (.link_clk(link_clk), .fwd_clk(fck_a), .pairs(pr_a), .ovr(ovr_a), .valid(valid),
                    .word(word_a), .flag(flag_a));
  ddr_capture rx_b (.link_clk(link_clk), .fwd_clk(fck_b), .pairs(pr_b), .ovr(ovr_b), .valid(valid),
                    .word(word_b), .flag(flag_b));

  // clocks: link phase offset keeps the two domains unrelated
  initial begin
    core_clk = 0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 0;
    #3.1;
    forever #7.5 link_clk = ~link_clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    total_checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("[FAIL] %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_rng
  // classic single cycle; called right after a rising edge, waits for ack without a cycle guess
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
    do @(posedge core_clk); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge core_clk);
  endtask : wb
  task automatic wait_valid();
    n = 0;
    while (valid !== 1'b1 && n < 400) begin
      @(posedge core_clk);
      n++;
    end
  endtask : wait_valid
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict

  // hang guard, well above the few thousand cycles the run needs
  always @(posedge core_clk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      $display("[FAIL] timeout expected finish seen hang");
      print_verdict();
    end
  end

  initial begin
    rst = 1; link_rst = 1; enable_pin = 0; samp_a = 12'h800; samp_b = 12'h800;
    cyc = 0; stb = 0; we = 0; adr = 8'h00; sel = 4'h0; wdat = 32'h0; cyc_cnt = 0;
    err_total = 0; total_checks = 0;
    repeat (20) @(posedge core_clk);
    rst <= 0; link_rst <= 0;
    repeat (2) @(posedge core_clk);
    wb(0, conv_out_pkg::CTRL_OFS, 32'h0); chk("ctrl reset", 32'hf0, rdat);
    wb(0, conv_out_pkg::POWER_MODE_OFS, 32'h0); chk("mode reset", 32'h0, rdat);
    wb(1, 8'h0c, 32'h5a); wb(0, 8'h0c, 32'h0); chk("unmapped", 32'h0, rdat);
    $display("test registers done");
    // every sleep mode: sleep with enable low, time the wake-up
    for (int m = 0; m < 4; m++) begin
      wb(1, conv_out_pkg::POWER_MODE_OFS, 32'(m));
      wb(0, conv_out_pkg::POWER_MODE_OFS, 32'h0); chk("mode readback", 32'(m), rdat);
      enable_pin <= 0;
      repeat (10) @(posedge core_clk);
      chk("asleep valid", 32'h0, {31'h0, valid});
      enable_pin <= 1;
      wait_valid();
      chk_rng("wake cycles", WAKE_SIM[m] + 80, WAKE_SIM[m] + 92, n);
    end
    wb(0, conv_out_pkg::STATUS_OFS, 32'h0); chk("status", 32'h7, rdat);
    $display("test sleep done");
    // a step held long enough for the asynchronous link to catch it
    for (int i = 0; i < 4; i++) begin
      // the first write keeps the reset settings, so no refill follows it
      wb(1, conv_out_pkg::CTRL_OFS, 32'hf0 | 32'(i)); chk("refill valid", 32'(i == 0), {31'h0, valid});
      wait_valid();
      repeat (100) @(posedge core_clk);
      mk = 12'h9a0 + 12'(i);
      samp_a <= mk; samp_b <= mk ^ 12'h300; n = 0;
      while (word_a !== mk && n < 300) begin
        @(posedge core_clk);
        n++;
      end
      chk_rng("data latency", LAT[i], LAT[i] + 24, n);
      repeat (40) @(posedge core_clk);
      chk("chan b word", {20'h0, mk ^ 12'h300}, {20'h0, word_b});
      samp_a <= 12'h800; samp_b <= 12'h800;
    end
    $display("test latency done");
    // threshold 4 gives a boundary of 512 codes from mid-scale
    wb(1, conv_out_pkg::CTRL_OFS, 32'h40);
    wait_valid();
    samp_a <= 12'h9ff;
    repeat (60) @(posedge core_clk);
    chk("flag below", 32'h0, {31'h0, flag_a});
    samp_a <= 12'ha00; n = 0;
    while (flag_a !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    chk_rng("flag latency", conv_out_pkg::LAT_OVR, conv_out_pkg::LAT_OVR + 24, n);
    $display("test overrange done");
    print_verdict();
  end
endmodule : tb_conv_out
